// File: hbl_addr_gen.sv
// transfer address and base write-back computation
`timescale 1ns/1ps
module hbl_addr_gen
  import hbl_pkg::*;
(
  // operands
  input  wire logic [31:0] base_value,
  input  wire logic [31:0] offset_value,
  input  wire logic [31:0] instr_addr,
  // addressing bits
  input  wire logic        base_is_pc,
  input  wire logic        pre_index,
  input  wire logic        up,
  input  wire logic        write_back,
  // results
  output wire logic [31:0] xfer_addr,
  output wire logic [31:0] new_base,
  output wire logic        base_update
);
  // pipelined program counter reads ahead of the instruction
  wire logic [31:0] base_eff = base_is_pc ? instr_addr + HBL_PC_BASE_OFS : base_value; // RL13
  wire logic [31:0] moved    = up ? base_eff + offset_value : base_eff - offset_value;
  assign xfer_addr   = pre_index ? moved : base_eff;
  assign new_base    = moved;
  // post-index always writes back; pre-index only with w set; pc base never
  assign base_update = (!pre_index || write_back) && !base_is_pc; // RL19 RL14
endmodule

// File: hbl_lane_extract.sv
// load lane selection and sign/zero extension
`timescale 1ns/1ps
module hbl_lane_extract
  import hbl_pkg::*;
(
  // control
  input  wire logic       endian_select,
  input  wire hbl_xfer_e  kind,
  input  wire logic [1:0] lane,
  // data
  input  wire logic [31:0] bus_data,
  output wire logic [31:0] load_value
);
  // ----------------------------------------------------------------
  // lane pick
  // ----------------------------------------------------------------
  wire logic [1:0]  byte_idx  = endian_select ? ~lane : lane;      // RL1 RL2 RL5
  wire logic [7:0]  byte_pick = bus_data[{byte_idx, 3'b000} +: 8]; // RL1 RL2 RL5
  wire logic        half_idx  = endian_select ? ~lane[1] : lane[1]; // RL4 RL6
  wire logic [15:0] half_pick = half_idx ? bus_data[31:16] : bus_data[15:0]; // RL4 RL6
  // ----------------------------------------------------------------
  // extension
  // ----------------------------------------------------------------
  wire logic [31:0] sbyte_ext = {{24{byte_pick[7]}}, byte_pick}; // RL3
  wire logic [31:0] shalf_ext = {{16{half_pick[15]}}, half_pick}; // RL8
  wire logic [31:0] uhalf_ext = {16'h0000, half_pick};            // RL7
  assign load_value = (kind == HBL_XFER_SBYTE) ? sbyte_ext :
                      (kind == HBL_XFER_SHALF) ? shalf_ext :
                      (kind == HBL_XFER_UHALF) ? uhalf_ext : 32'h0000_0000;
endmodule

// File: hbl_lanes.sv
// halfword/signed-byte load-store lane engine with ahb-lite register port
//
// Overview of operation
// RL1: le signed byte lane follows address offset
// RL2: remaining byte lanes continue pattern both endians
// RL3: byte sign bit fills upper destination bits
// RL4: le halfword lanes by address bit one
// RL5: be signed byte lane from top down
// RL6: be halfword lanes reversed by bit one
// RL7: unsigned halfword zero-fills upper half
// RL8: signed halfword sign-fills upper half
// RL9: odd halfword load address gives unpredictable
// RL10: halfword store replicates low half twice
// RL11: memory enables only the addressed halfword
// RL12: store address bit zero kept low (the code passes bit 0 through and only flags it in status)
// RL13: pc base reads instruction address plus 8
// RL14: no write-back or offset with pc
// RL15: stored pc is instruction address plus 12
// RL16: abort input takes data abort trap
// RL17: cycle counts 1S1N1I, 2S2N1I, 2N
// RL18: signed variants are load-only
// RL19: pre-index writes base only when w set
// RL20: endian input selects lane mapping
// RL21: s and h bits pick transfer kind
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module hbl_lanes
  import hbl_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // endian pin
  input  wire logic        endian_select,
  // memory side
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_abort,
  output logic [31:0]      mem_addr_r,
  output logic [31:0]      mem_wdata_r,
  output logic             mem_req_r,
  output logic             mem_write_r,
  output logic             mem_half_r,
  output logic             abort_trap_r
);
  typedef enum {ST_IDLE, ST_XFER, ST_WAIT} hbl_state_e;

  // ----------------------------------------------------------------
  // endian pin synchroniser: three flops, change once 2 and 3 agree
  // ----------------------------------------------------------------
  logic [2:0] be_sync_r;
  logic       be_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      be_sync_r <= 3'h0;
      be_r      <= 1'b0;
    end
    else
    begin
      be_sync_r <= {be_sync_r[1:0], endian_select};
      if (be_sync_r[1] == be_sync_r[2])
        be_r <= be_sync_r[2]; // RL20
    end
  end

  // ----------------------------------------------------------------
  // bus address phase capture
  // ----------------------------------------------------------------
  logic        dph_wr_r;
  logic        dph_rd_r;
  logic [7:0]  dph_addr_r;
  wire  logic  take_req = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr_r   <= 1'b0;
      dph_rd_r   <= 1'b0;
      dph_addr_r <= 8'h00;
    end
    else
    begin
      dph_wr_r   <= take_req && hwrite;
      dph_rd_r   <= take_req && !hwrite;
      dph_addr_r <= take_req ? haddr[7:0] : dph_addr_r;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [31:0] addr_r;
  logic [31:0] src_r;
  logic [31:0] base_r;
  logic [31:0] offset_r;
  logic [7:0]  cmd_r;
  logic [31:0] result_r;
  logic [31:0] newbase_r;
  logic [3:0]  cycles_r;
  logic [4:0]  status_r;
  logic        busy_r;
  hbl_state_e  state_r;
  hbl_state_e  state_nxt;

  wire logic wr_addr   = dph_wr_r && (dph_addr_r == HBL_OFF_ADDR);
  wire logic wr_src    = dph_wr_r && (dph_addr_r == HBL_OFF_SRC);
  wire logic wr_base   = dph_wr_r && (dph_addr_r == HBL_OFF_BASE);
  wire logic wr_offset = dph_wr_r && (dph_addr_r == HBL_OFF_OFFSET);
  wire logic wr_cmd    = dph_wr_r && (dph_addr_r == HBL_OFF_CMD) && !busy_r;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire logic [7:0] cw      = hwdata[7:0];
  wire logic       c_h     = cw[HBL_CMD_H_BIT];
  wire logic       c_s     = cw[HBL_CMD_S_BIT];
  wire logic       c_l     = cw[HBL_CMD_L_BIT];
  // signed variants with load clear are illegal, and s=0,h=0 is not ours
  wire logic       c_ill   = (c_s && !c_l) || (!c_s && !c_h); // RL18 RL21
  wire hbl_xfer_e  c_kind  = !c_s ? HBL_XFER_UHALF :
                             (c_h ? HBL_XFER_SHALF : HBL_XFER_SBYTE); // RL21
  hbl_xfer_e kind_r;

  // ----------------------------------------------------------------
  // address generation and load lanes
  // ----------------------------------------------------------------
  wire logic [31:0] xfer_addr;
  wire logic [31:0] new_base;
  wire logic        base_update;
  wire logic [31:0] load_value;
  hbl_addr_gen u_addr
  (
    .base_value   (base_r),
    .offset_value (offset_r),
    .instr_addr   (addr_r),
    .base_is_pc   (cmd_r[HBL_CMD_PCB_BIT]),
    .pre_index    (cmd_r[HBL_CMD_P_BIT]),
    .up           (cmd_r[HBL_CMD_U_BIT]),
    .write_back   (cmd_r[HBL_CMD_W_BIT]),
    .xfer_addr    (xfer_addr),
    .new_base     (new_base),
    .base_update  (base_update)
  );
  hbl_lane_extract u_lane
  (
    .endian_select (be_r),
    .kind          (kind_r),
    .lane          (mem_addr_r[1:0]),
    .bus_data      (mem_rdata),
    .load_value    (load_value)
  );

  // pc as store source reads one stage further ahead
  wire logic [31:0] store_src = cmd_r[HBL_CMD_PCD_BIT] ? addr_r + HBL_PC_STORE_OFS : src_r; // RL15
  wire logic [3:0]  cyc_cost  = !cmd_r[HBL_CMD_L_BIT] ? HBL_CYC_STORE :
                                (cmd_r[HBL_CMD_PCD_BIT] ? HBL_CYC_LOAD_PC : HBL_CYC_LOAD); // RL17

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (wr_cmd && !c_ill) state_nxt = ST_XFER;
      ST_XFER: state_nxt = ST_WAIT;
      ST_WAIT: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_IDLE;
      kind_r  <= HBL_XFER_NONE;
      cmd_r   <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      if (wr_cmd && !c_ill)
      begin
        cmd_r  <= cw;
        kind_r <= c_kind;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r   <= HBL_RESET_WORD;
      src_r    <= HBL_RESET_WORD;
      base_r   <= HBL_RESET_WORD;
      offset_r <= HBL_RESET_WORD;
    end
    else
    begin
      if (wr_addr)
        addr_r <= hwdata;
      if (wr_src)
        src_r <= hwdata;
      if (wr_offset)
        offset_r <= hwdata;
      if (wr_base)
        base_r <= hwdata;
      else if (state_r == ST_WAIT && !mem_abort && base_update)
        base_r <= new_base; // RL19
    end
  end

  // memory outputs, all from flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_addr_r  <= HBL_RESET_WORD;
      mem_wdata_r <= HBL_RESET_WORD;
      mem_req_r   <= 1'b0;
      mem_write_r <= 1'b0;
      mem_half_r  <= 1'b0;
    end
    else
    begin
      mem_req_r <= (state_r == ST_XFER);
      if (state_r == ST_XFER)
      begin
        mem_addr_r  <= xfer_addr;
        mem_write_r <= !cmd_r[HBL_CMD_L_BIT];
        mem_half_r  <= kind_r != HBL_XFER_SBYTE;
        mem_wdata_r <= {store_src[15:0], store_src[15:0]}; // RL10 RL11
      end
    end
  end

  // results and status; done/abort set wins over software clear
  wire logic st_clr = dph_wr_r && (dph_addr_r == HBL_OFF_STATUS);
  wire logic fin    = (state_r == ST_WAIT);
  wire logic ld_fin = fin && !mem_abort && cmd_r[HBL_CMD_L_BIT];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      result_r     <= HBL_RESET_WORD;
      newbase_r    <= HBL_RESET_WORD;
      cycles_r     <= 4'h0;
      status_r     <= 5'h00;
      busy_r       <= 1'b0;
      abort_trap_r <= 1'b0;
    end
    else
    begin
      busy_r       <= (state_nxt != ST_IDLE);
      abort_trap_r <= fin && mem_abort; // RL16
      if (ld_fin)
        result_r <= load_value; // RL3 RL7 RL8
      if (fin)
      begin
        newbase_r <= new_base;
        cycles_r  <= cyc_cost; // RL17
      end
      status_r[HBL_ST_DONE_BIT]  <= fin || (status_r[HBL_ST_DONE_BIT] && !st_clr);
      status_r[HBL_ST_ABORT_BIT] <= (fin && mem_abort) ||
                                    (status_r[HBL_ST_ABORT_BIT] && !st_clr); // RL16
      status_r[HBL_ST_ILL_BIT]   <= (wr_cmd && c_ill) ||
                                    (status_r[HBL_ST_ILL_BIT] && !st_clr); // RL18
      // odd halfword address flagged; the loaded value is then undefined
      status_r[HBL_ST_UNPR_BIT]  <= (fin && mem_half_r && mem_addr_r[0]) ||
                                    (status_r[HBL_ST_UNPR_BIT] && !st_clr); // RL9 RL12
      status_r[HBL_ST_BUSY_BIT]  <= (state_nxt != ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // read mux; unmapped reads return zero
  // ----------------------------------------------------------------
  wire logic [31:0] rd_mux =
    (dph_addr_r == HBL_OFF_CTRL)    ? {31'h0, be_r} :
    (dph_addr_r == HBL_OFF_ADDR)    ? addr_r :
    (dph_addr_r == HBL_OFF_SRC)     ? src_r :
    (dph_addr_r == HBL_OFF_BASE)    ? base_r :
    (dph_addr_r == HBL_OFF_OFFSET)  ? offset_r :
    (dph_addr_r == HBL_OFF_CMD)     ? {24'h0, cmd_r} :
    (dph_addr_r == HBL_OFF_STATUS)  ? {27'h0, status_r} :
    (dph_addr_r == HBL_OFF_RESULT)  ? result_r :
    (dph_addr_r == HBL_OFF_WDATA)   ? mem_wdata_r :
    (dph_addr_r == HBL_OFF_NEWBASE) ? newbase_r :
    (dph_addr_r == HBL_OFF_CYCLES)  ? {28'h0, cycles_r} : 32'h0000_0000;

  // read data registered: answered one wait state later
  logic rd_pend_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      rd_pend_r <= 1'b0;
    end
    else
    begin
      rd_pend_r <= take_req && !hwrite;
      hreadyout <= !(take_req && !hwrite);
      if (rd_pend_r)
        hrdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // lane checks look at loads only: stores leave result_r stale
  a_store_repl: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
    mem_req_r && mem_write_r |-> mem_wdata_r[31:16] == mem_wdata_r[15:0])
    else $error("store halves differ");
  a_abort_trap: assert property (@(posedge hclk) disable iff (!hresetn) // RL16
    (state_r == ST_WAIT) && mem_abort |=> abort_trap_r && status_r[HBL_ST_ABORT_BIT])
    else $error("abort not trapped");
  a_uhalf_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
    ld_fin && kind_r == HBL_XFER_UHALF |=> result_r[31:16] == 16'h0000)
    else $error("unsigned half not zero filled");
  a_shalf_sign: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
    ld_fin && kind_r == HBL_XFER_SHALF |=> result_r[31:16] == {16{result_r[15]}})
    else $error("signed half not sign filled");
  a_sbyte_sign: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
    ld_fin && kind_r == HBL_XFER_SBYTE |=> result_r[31:8] == {24{result_r[7]}})
    else $error("signed byte not sign filled");
  a_le_byte: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
    ld_fin && kind_r == HBL_XFER_SBYTE && !be_r && mem_addr_r[1:0] == 2'h1
    |=> result_r[7:0] == $past(mem_rdata[15:8]))
    else $error("le byte lane wrong");
  a_be_byte: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
    ld_fin && kind_r == HBL_XFER_SBYTE && be_r && mem_addr_r[1:0] == 2'h0
    |=> result_r[7:0] == $past(mem_rdata[31:24]))
    else $error("be byte lane wrong");
  a_le_half: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
    ld_fin && kind_r != HBL_XFER_SBYTE && !be_r && mem_addr_r[1]
    |=> result_r[15:0] == $past(mem_rdata[31:16]))
    else $error("le half lane wrong");
  a_be_half: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
    ld_fin && kind_r != HBL_XFER_SBYTE && be_r && mem_addr_r[1]
    |=> result_r[15:0] == $past(mem_rdata[15:0]))
    else $error("be half lane wrong");
  a_store_cycles: assert property (@(posedge hclk) disable iff (!hresetn) // RL17
    fin && !cmd_r[HBL_CMD_L_BIT] |=> cycles_r == HBL_CYC_STORE)
    else $error("store cycle count wrong");
  c_store: cover property (@(posedge hclk) mem_req_r && mem_write_r);
  c_load:  cover property (@(posedge hclk) mem_req_r && !mem_write_r);
  c_abort: cover property (@(posedge hclk) abort_trap_r);
endmodule

// File: hbl_mem_model.sv
// external memory partner model for the lane block
`timescale 1ns/1ps
module hbl_mem_model
(
  // clock
  input  wire logic        hclk,
  // transfer side
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic        mem_half,
  input  wire logic        endian_select,
  // scenario control
  input  wire logic        abort_en,
  output logic [31:0]      mem_rdata,
  output logic             mem_abort
);
  // ----------------------------------------------------------------
  // storage and lanes
  // ----------------------------------------------------------------
  logic [31:0] mem [16];
  logic [31:0] junk = 32'h5A5A_A5A5;
  logic        hi_lane;

  // idle bus carries a moving pattern so stale data is never mistaken for a reply
  assign mem_rdata = mem_req ? mem[mem_addr[5:2]] : junk;
  assign mem_abort = mem_req & abort_en;
  // bit 0 of the store address is ignored; bit 1 and the endian pin pick the written half
  assign hi_lane   = endian_select ? ~mem_addr[1] : mem_addr[1];

  always @(posedge hclk)
  begin
    junk <= {junk[30:0], ~junk[31]} ^ 32'h0000_0009;
    if (mem_req && mem_write && mem_half && !abort_en)
    begin
      if (hi_lane)
        mem[mem_addr[5:2]][31:16] <= mem_wdata[31:16];
      else
        mem[mem_addr[5:2]][15:0] <= mem_wdata[15:0];
    end
  end
endmodule

// File: hbl_pkg.sv
// package: constants and types for the halfword/byte load-store lane block
package hbl_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] HBL_OFF_CTRL   = 8'h00;
  localparam logic [7:0] HBL_OFF_ADDR   = 8'h04;
  localparam logic [7:0] HBL_OFF_SRC    = 8'h08;
  localparam logic [7:0] HBL_OFF_BASE   = 8'h0C;
  localparam logic [7:0] HBL_OFF_OFFSET = 8'h10;
  localparam logic [7:0] HBL_OFF_CMD    = 8'h14;
  localparam logic [7:0] HBL_OFF_STATUS = 8'h18;
  localparam logic [7:0] HBL_OFF_RESULT = 8'h1C;
  localparam logic [7:0] HBL_OFF_WDATA  = 8'h20;
  localparam logic [7:0] HBL_OFF_NEWBASE = 8'h24;
  localparam logic [7:0] HBL_OFF_CYCLES = 8'h28;
  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int HBL_CMD_H_BIT    = 0;
  localparam int HBL_CMD_S_BIT    = 1;
  localparam int HBL_CMD_L_BIT    = 2;
  localparam int HBL_CMD_W_BIT    = 3;
  localparam int HBL_CMD_P_BIT    = 4;
  localparam int HBL_CMD_U_BIT    = 5;
  localparam int HBL_CMD_PCB_BIT  = 6;
  localparam int HBL_CMD_PCD_BIT  = 7;
  // status fields
  localparam int HBL_ST_BUSY_BIT  = 0;
  localparam int HBL_ST_DONE_BIT  = 1;
  localparam int HBL_ST_ABORT_BIT = 2;
  localparam int HBL_ST_ILL_BIT   = 3;
  localparam int HBL_ST_UNPR_BIT  = 4;
  // control fields
  localparam int HBL_CTRL_BE_BIT  = 0;
  // ----------------------------------------------------------------
  // pipeline offsets and cycle counts
  // ----------------------------------------------------------------
  localparam logic [31:0] HBL_PC_BASE_OFS  = 32'h0000_0008;
  localparam logic [31:0] HBL_PC_STORE_OFS = 32'h0000_000C;
  localparam logic [3:0]  HBL_CYC_LOAD     = 4'h3;
  localparam logic [3:0]  HBL_CYC_LOAD_PC  = 4'h5;
  localparam logic [3:0]  HBL_CYC_STORE    = 4'h2;
  localparam logic [31:0] HBL_RESET_WORD   = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    HBL_XFER_NONE,
    HBL_XFER_UHALF,
    HBL_XFER_SBYTE,
    HBL_XFER_SHALF
  } hbl_xfer_e;
endpackage

// File: tb_hbl_lanes.sv
// self-checking testbench for the lane block
`timescale 1ns/1ps
module tb_hbl_lanes
  import hbl_pkg::*;
;
  // ----------------------------------------------------------------
  // signals, queues and helpers
  // ----------------------------------------------------------------
  typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} hbl_tb_note_s;
  typedef struct {logic [31:0] addr; logic [31:0] wd; logic [31:0] wm; logic [1:0] kd;} hbl_tb_mem_s;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        endian_select = 1'b0;
  logic        abort_en = 1'b0;
  logic [31:0] hrdata, mem_rdata, mem_addr_r, mem_wdata_r;
  logic        hreadyout, hresp, mem_abort, mem_req_r, mem_write_r, mem_half_r, abort_trap_r;
  logic [31:0] seed = 32'h577F_F8A9;
  logic        rd_ph = 1'b0;
  int          fails = 0, n_tests = 0, n_trap = 0, n_cyc = 0;
  hbl_tb_note_s bus_q[$];
  hbl_tb_mem_s  mem_q[$];

  always #25 hclk = ~hclk;

  hbl_lanes u_hbl_lanes (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .endian_select(endian_select),
    .mem_rdata(mem_rdata), .mem_abort(mem_abort), .mem_addr_r(mem_addr_r),
    .mem_wdata_r(mem_wdata_r), .mem_req_r(mem_req_r), .mem_write_r(mem_write_r),
    .mem_half_r(mem_half_r), .abort_trap_r(abort_trap_r));

  hbl_mem_model u_hbl_mem_model (.hclk(hclk), .mem_addr(mem_addr_r), .mem_wdata(mem_wdata_r),
    .mem_req(mem_req_r), .mem_write(mem_write_r), .mem_half(mem_half_r),
    .endian_select(endian_select), .abort_en(abort_en), .mem_rdata(mem_rdata),
    .mem_abort(mem_abort));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected load value from the word on the bus
  function automatic logic [31:0] ext(input int k, input logic be, input logic [1:0] a,
                                      input logic [31:0] w);
    logic [7:0]  b;
    logic [15:0] h;
    b = w[8 * (be ? 3 - a : a) +: 8];
    h = (be ^ a[1]) ? w[31:16] : w[15:0];
    if (k == 2)
      return {{24{b[7]}}, b};
    if (k == 3)
      return {{16{h[15]}}, h};
    return {16'h0, h};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watcher: takes the oldest note as each result appears
  // ----------------------------------------------------------------
  always @(posedge hclk)
  begin
    hbl_tb_note_s n;
    hbl_tb_mem_s  m;
    n_cyc++;
    if (n_cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
    if (rd_ph && hreadyout === 1'b1)
    begin
      n = bus_q.pop_front();
      check(n.nm, hrdata & n.msk, n.exp & n.msk);
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    if (hreadyout === 1'b1)
      rd_ph = htrans[1] & ~hwrite;
    // a request with no note pending is an unexpected transfer
    if (mem_req_r === 1'b1 && mem_q.size() == 0)
      check("mem_req", 32'h1, 32'h0);
    else if (mem_req_r === 1'b1)
    begin
      m = mem_q.pop_front();
      check("mem_addr", mem_addr_r, m.addr);
      check("mem_kind", {30'h0, mem_write_r, mem_half_r}, {30'h0, m.kd});
      check("mem_wdata", mem_wdata_r & m.wm, m.wd & m.wm);
    end
    if (abort_trap_r === 1'b1)
      n_trap++;
  end

  // ----------------------------------------------------------------
  // bus tasks and operations
  // ----------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, output logic [31:0] v);
    bus_q.push_back('{nm, e, m});
    ahb(1'b0, a, 32'h0, v);
  endtask

  task automatic op(input logic [7:0] cmd, input logic [31:0] ins, src, base, ofs);
    logic [31:0] v;
    int          k;
    wr(HBL_OFF_ADDR, ins);
    wr(HBL_OFF_SRC, src);
    wr(HBL_OFF_BASE, base);
    wr(HBL_OFF_OFFSET, ofs);
    wr(HBL_OFF_STATUS, 32'h0);
    wr(HBL_OFF_CMD, {24'h0, cmd});
    v = 32'h0;
    for (k = 0; k < 40 && v[1] !== 1'b1 && v[3] !== 1'b1; k++)
      rd("poll", HBL_OFF_STATUS, 32'h0, 32'h0, v);
    if (k == 40)
      fails++;
  endtask

  task automatic post(input logic [31:0] r, rm, input logic [4:0] st, sm,
                      input logic [31:0] nb, nm, input logic [3:0] cyc, cm);
    logic [31:0] v;
    rd("result", HBL_OFF_RESULT, r, rm, v);
    rd("status", HBL_OFF_STATUS, {27'h0, st}, {27'h0, sm}, v);
    rd("base", HBL_OFF_BASE, nb, nm, v);
    rd("cycles", HBL_OFF_CYCLES, {28'h0, cyc}, {28'h0, cm}, v);
  endtask

  // bits: 0 up, 1 pre-index, 2 write-back, 3 pc destination
  task automatic ld(input int k, input logic [31:0] base, ofs, ins, input logic [3:0] bits,
                    input logic pb, input logic [4:0] st);
    logic [31:0] b0, cb, addr, nb;
    logic        w;
    w = bits[2] & bits[1] & ~pb;
    b0 = pb ? ins + HBL_PC_BASE_OFS : base;
    cb = bits[0] ? b0 + ofs : b0 - ofs;
    addr = bits[1] ? cb : b0;
    nb = ((bits[1] & ~w) | st[2]) ? base : cb;
    mem_q.push_back('{addr, 32'h0, 32'h0, {1'b0, k != 2}});
    op({bits[3], pb, bits[0], bits[1], w, 1'b1, k[1:0]}, ins, rnd(), base, ofs);
    post(ext(k, endian_select, addr[1:0], u_hbl_mem_model.mem[addr[5:2]]),
         (st[4] | st[2]) ? 32'h0 : 32'hFFFF_FFFF, st, 5'h1F, nb,
         pb ? 32'h0 : 32'hFFFF_FFFF, bits[3] ? HBL_CYC_LOAD_PC : HBL_CYC_LOAD, 4'hF);
    rd("new_base", HBL_OFF_NEWBASE, cb, 32'hFFFF_FFFF, nb);
  endtask

  task automatic sto(input logic [31:0] base, src, ins, input logic pd);
    logic [31:0] d, old;
    logic [3:0]  i;
    i = base[5:2];
    d = pd ? ins + HBL_PC_STORE_OFS : src;
    old = u_hbl_mem_model.mem[i];
    mem_q.push_back('{base, {d[15:0], d[15:0]}, 32'hFFFF_FFFF, 2'h3});
    op({pd, 7'h31}, ins, src, base, 32'h0);
    post(32'h0, 32'h0, 5'h02, 5'h1F, base, 32'hFFFF_FFFF, HBL_CYC_STORE, 4'hF);
    check("mem_word", u_hbl_mem_model.mem[i], (endian_select ^ base[1]) ?
          {d[15:0], old[15:0]} : {old[31:16], d[15:0]});
  endtask

  initial
  begin
    logic [31:0] v, b, r;
    int          be, k, a;
    for (k = 0; k < 16; k++)
      u_hbl_mem_model.mem[k] = rnd();
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd("status", HBL_OFF_STATUS, HBL_RESET_WORD, 32'hFFFF_FFFF, v);
    rd("result", HBL_OFF_RESULT, HBL_RESET_WORD, 32'hFFFF_FFFF, v);
    wr(8'h40, 32'hFFFF_FFFF);
    rd("unmapped", 8'h40, 32'h0, 32'hFFFF_FFFF, v);
    $display("test reset done");
    for (be = 0; be < 2; be++)
    begin
      endian_select <= be[0];
      repeat (8) @(posedge hclk);
      rd("endian", HBL_OFF_CTRL, {31'h0, be[0]}, 32'h1, v);
      for (k = 1; k < 4; k++)
        for (a = 0; a < 4; a++)
          if (k == 2 || a[0] == 1'b0)
          begin
            b = rnd();
            b[1:0] = a[1:0];
            r = rnd();
            ld(k, b, rnd() & 32'h3C, rnd() & 32'hFFFF_FFFC, r[3:0], 1'b0, 5'h02);
          end
      for (a = 0; a < 4; a += 2)
      begin
        b = rnd() & 32'hFFFF_FFFC;
        b[1] = a[1];
        sto(b, rnd(), rnd() & 32'hFFFF_FFFC, a[1]);
      end
      $display("test lanes endian %0d done", be);
    end
    ld(1, rnd() & 32'hFFFF_FFFC, 32'h4, rnd() & 32'hFFFF_FFFC, 4'h3, 1'b1, 5'h02);
    b = rnd() | 32'h1;
    ld(3, b, 32'h0, rnd() & 32'hFFFF_FFFC, 4'h3, 1'b0, 5'h12);
    for (k = 2; k < 5; k++)
    begin
      op(k[7:0], 32'h0, rnd(), rnd(), 32'h0);
      post(32'h0, 32'h0, 5'h08, 5'h08, 32'h0, 32'h0, 4'h0, 4'h0);
    end
    $display("test pc odd illegal done");
    abort_en <= 1'b1;
    ld(1, rnd() & 32'hFFFF_FFFC, 32'h4, rnd() & 32'hFFFF_FFFC, 4'h7, 1'b0, 5'h06);
    abort_en <= 1'b0;
    check("trap_count", n_trap, 32'h1);
    $display("test abort done");
    report_and_stop();
  end
endmodule
